// ### rtl/kms_pkg.sv
// Constants, types and the default code tables for the key matrix scanner.
// Assumes a 40 MHz system clock and a passive 8 x 7 switch matrix.
`default_nettype none
package kms_pkg;
  // ----------------------------------------------------------------
  // Geometry and fixed key positions, index is {column, row}
  // ----------------------------------------------------------------
  localparam int NUM_ROWS = 8;
  localparam int NUM_COLS = 7;
  localparam logic [5:0] BRK_IDX = 6'h36;
  localparam logic [5:0] CTRL_IDX = 6'h35;
  localparam logic [5:0] SHIFT_IDX = 6'h37;
  localparam logic [5:0] REPT_IDX = 6'h2e;
  localparam logic [2:0] BRK_ROW = 3'h6;
  localparam logic [2:0] LAST_ROW = 3'h7;
  localparam logic [2:0] LAST_COL = 3'h6;
  localparam logic [7:0] CASE_BIT = 8'h20;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SCAN_MS = 20;
  localparam int REPEAT_MS = 100;
  localparam int SCAN_CYC_DEF = SCAN_MS * CLK_MHZ * 1000;
  localparam int REPEAT_CYC_DEF = REPEAT_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 24;

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_EMIT} kms_state_t;

  typedef struct packed {
    logic en;
    logic shifted;
    logic [5:0] addr;
    logic [7:0] data;
  } kms_tbl_wr_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } kms_key_t;

  function automatic logic kms_is_alpha(input logic [7:0] c);
    return ((c >= 8'h41) && (c <= 8'h5a)) || ((c >= 8'h61) && (c <= 8'h7a));
  endfunction

  // Standard table; letters upper case unshifted, lower case shifted
  function automatic logic [7:0] kms_default_code(input logic sh,
      input logic [2:0] c, input logic [2:0] r);
    logic [7:0] v;
    v = 8'h00;
    unique case (c)
      3'h0: v = 8'h30 + {5'h00, r};
      3'h1: v = (r < 3'h2) ? 8'h38 + {5'h00, r} :
                (r < 3'h4) ? 8'h38 + {5'h00, r} : 8'h28 + {5'h00, r};
      3'h2: v = (r == 3'h0) ? 8'h0d : 8'h40 + {5'h00, r};
      3'h3: v = 8'h48 + {5'h00, r};
      3'h4: v = 8'h50 + {5'h00, r};
      3'h5: v = (r < 3'h4) ? 8'h58 + {5'h00, r} :
                (r == 3'h4) ? 8'h5e : (r == 3'h5) ? 8'h20 :
                (r == 3'h6) ? 8'h00 : 8'h7f;
      default: v = (r < 3'h4) ? 8'h10 + {5'h00, r} :
                   (r == 3'h4) ? 8'h09 : (r == 3'h6) ? 8'h03 : 8'h00;
    endcase
    if (sh && kms_is_alpha(v)) v = v | CASE_BIT;
    else if (sh && c < 3'h2) v = v ^ 8'h10;
    return v;
  endfunction
endpackage
`default_nettype wire

// ### rtl/kms_scan.sv
// Key matrix scanner and encoder: drives rows, reads columns, emits codes.
// Assumes column inputs are synchronous, high while a key on the row is down.
`timescale 1ns/1ps
`default_nettype none
module kms_scan #(
  parameter int SCAN_CYC = kms_pkg::SCAN_CYC_DEF,
  parameter int REPEAT_CYC = kms_pkg::REPEAT_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  output logic [7:0] row_drive,
  input wire logic [6:0] col_sense,
  input wire logic break_only,
  input wire kms_pkg::kms_tbl_wr_t tbl_wr,
  output kms_pkg::kms_key_t key_out,
  output logic break_hit,
  output logic case_inv
);
  import kms_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  kms_state_t state;
  logic [CNT_W-1:0] scan_cnt;
  logic [CNT_W-1:0] rep_cnt;
  logic [5:0] settle_cnt;
  logic [2:0] row;
  logic [2:0] col;
  logic [6:0] cols;
  logic [6:0] held [NUM_ROWS];
  logic [7:0] tbl [128];
  logic brk_mode;
  logic rep_due;
  logic rep_pass;

  // ----------------------------------------------------------------
  // Per-key decisions in the emit walk
  // ----------------------------------------------------------------
  logic [5:0] idx;
  logic press;
  logic prev;
  logic consider;
  logic is_mod;
  logic fire;
  logic new_press;
  logic shift_on;
  logic rept_on;
  logic [7:0] lookup;
  logic [7:0] next_code;
  logic scan_start;
  logic last_col;
  logic [6:0] wr_idx;

  assign idx = {col, row};
  assign press = cols[col];
  assign prev = held[row][col];
  assign consider = !brk_mode || (idx == BRK_IDX);
  assign is_mod = (idx == SHIFT_IDX) || (idx == CTRL_IDX) ||
                  (idx == REPT_IDX) || (idx == BRK_IDX);
  assign new_press = (state == ST_EMIT) && consider && press &&
                     !prev;
  assign fire = (state == ST_EMIT) && consider && press &&
                (!prev || rep_pass);
  assign shift_on = held[SHIFT_IDX[2:0]][SHIFT_IDX[5:3]];
  assign rept_on = held[REPT_IDX[2:0]][REPT_IDX[5:3]];
  assign lookup = tbl[{shift_on, idx}];
  assign next_code = (case_inv && kms_is_alpha(lookup)) ?
                     (lookup ^ CASE_BIT) : lookup;
  assign scan_start = (state == ST_IDLE) &&
                      (scan_cnt == CNT_W'(SCAN_CYC - 1));
  assign last_col = (state == ST_EMIT) && (col == LAST_COL);
  assign wr_idx = {tbl_wr.shifted, tbl_wr.addr};

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      scan_cnt <= '0;
      settle_cnt <= '0;
      row <= 3'h0;
      col <= 3'h0;
      cols <= 7'h00;
      row_drive <= 8'h00;
      brk_mode <= 1'b0;
    end else if (clk_en) begin
      unique case (state)
        ST_IDLE: begin
          scan_cnt <= scan_cnt + 1'b1;
          if (scan_start) begin
            scan_cnt <= '0;
            brk_mode <= break_only;
            // Break-only scan visits one row and so ends quickly
            row <= break_only ? BRK_ROW : 3'h0;
            row_drive <= 8'h01 << (break_only ? BRK_ROW : 3'h0);
            settle_cnt <= '0;
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          settle_cnt <= settle_cnt + 1'b1;
          if (settle_cnt == 6'(SETTLE_CYC - 1)) begin
            cols <= col_sense;
            col <= 3'h0;
            state <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          // Wrap after the last column so no select ever leaves the row
          col <= last_col ? 3'h0 : col + 1'b1;
          if (last_col) begin
            if (brk_mode || row == LAST_ROW) begin
              row_drive <= 8'h00;
              state <= ST_IDLE;
            end else begin
              row <= row + 1'b1;
              row_drive <= 8'h01 << (row + 1'b1);
              settle_cnt <= '0;
              state <= ST_SETTLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Key state memory and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_ROWS; i++) held[i] <= 7'h00;
      key_out <= '0;
      break_hit <= 1'b0;
      case_inv <= 1'b0;
    end else if (clk_en) begin
      key_out.valid <= 1'b0;
      break_hit <= 1'b0;
      if (state == ST_EMIT && consider) held[row][col] <= press;
      if (fire && !is_mod) begin
        key_out.valid <= 1'b1;
        key_out.code <= next_code;
      end
      if (new_press && idx == CTRL_IDX) case_inv <= !case_inv;
      if (new_press && idx == BRK_IDX) break_hit <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fixed-rate repeat timer; runs only while the repeat key is held
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rep_cnt <= '0;
      rep_due <= 1'b0;
      rep_pass <= 1'b0;
    end else if (clk_en) begin
      if (!rept_on) begin
        rep_cnt <= '0;
      end else if (rep_cnt == CNT_W'(REPEAT_CYC - 1)) begin
        rep_cnt <= '0;
      end else begin
        rep_cnt <= rep_cnt + 1'b1;
      end
      // A due tick landing on the scan start is kept for the next scan
      if (rept_on && rep_cnt == CNT_W'(REPEAT_CYC - 1)) begin
        rep_due <= 1'b1;
      end else if (scan_start) begin
        rep_due <= 1'b0;
      end
      if (scan_start) rep_pass <= rep_due && rept_on;
    end
  end

  // ----------------------------------------------------------------
  // User code tables
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 128; i++) begin
        tbl[i] <= kms_default_code(i[6], i[5:3], i[2:0]);
      end
    end else if (clk_en && tbl_wr.en) begin
      tbl[wr_idx] <= tbl_wr.data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_one_row;
    @(posedge sys_clk) disable iff (!rstn) $onehot0(row_drive);
  endproperty
  a_one_row: assert property (p_one_row)
    else $error("rows overlap");

  property p_settled;
    @(posedge sys_clk) disable iff (!rstn || !clk_en)
      (state == ST_SETTLE && settle_cnt == 6'(SETTLE_CYC - 1))
      |=> state == ST_EMIT && cols == $past(col_sense);
  endproperty
  a_settled: assert property (p_settled) else $error("bad sample");

  property p_new_only;
    @(posedge sys_clk) disable iff (!rstn || !clk_en)
      (state == ST_EMIT && prev && !rep_pass) |=> !key_out.valid;
  endproperty
  a_new_only: assert property (p_new_only)
    else $error("held key coded");

  property p_repeat;
    @(posedge sys_clk) disable iff (!rstn || !clk_en)
      (fire && rep_pass && prev && !is_mod) |=> key_out.valid;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat lost");

  property p_code;
    @(posedge sys_clk) disable iff (!rstn || !clk_en)
      (fire && !is_mod) |=> key_out.code == $past(next_code);
  endproperty
  a_code: assert property (p_code) else $error("wrong code");

  property p_brk_row;
    @(posedge sys_clk) disable iff (!rstn || !clk_en)
      (scan_start && break_only) |=> row_drive == 8'h40 [*2];
  endproperty
  a_brk_row: assert property (p_brk_row) else $error("break row");

  property p_brk_quiet;
    @(posedge sys_clk) disable iff (!rstn || !clk_en)
      (brk_mode && state == ST_EMIT) |=> !key_out.valid;
  endproperty
  a_brk_quiet: assert property (p_brk_quiet)
    else $error("code in break");

  property p_ctrl;
    @(posedge sys_clk) disable iff (!rstn || !clk_en)
      (new_press && idx == CTRL_IDX) |=> case_inv != $past(case_inv);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("no toggle");

  property p_tbl;
    @(posedge sys_clk) disable iff (!rstn || !clk_en)
      tbl_wr.en |=> tbl[$past(wr_idx)] == $past(tbl_wr.data);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table write lost");

  c_code: cover property (@(posedge sys_clk) key_out.valid);
  c_rep: cover property (@(posedge sys_clk) fire && rep_pass && prev);
  c_brk: cover property (@(posedge sys_clk) break_hit);
  c_inv: cover property (@(posedge sys_clk) key_out.valid && case_inv);
endmodule
`default_nettype wire

// ### verif/kms_matrix_model.sv
// Passive 8 x 7 switch matrix seen from the scanner's pins.
// Assumes held[{col,row}] is set by the bench while that key is down.
`timescale 1ns/1ps
`default_nettype none
module kms_matrix_model (
  input wire logic [7:0] row_drive,
  input wire logic [55:0] held,
  output logic [6:0] col_sense
);
  // ----------------------------------------------------------------
  // Switch array
  // ----------------------------------------------------------------
  // Columns have pull-downs: an undriven row or open switch reads 0
  always_comb begin
    col_sense = 7'h00;
    for (int c = 0; c < 7; c++) begin
      for (int r = 0; r < 8; r++) begin
        if (row_drive[r] && held[c * 8 + r]) col_sense[c] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/key_matrix_scan_encoder_tb_top.sv
// Self-checking bench for the key matrix scanner.
// Assumes kms_pkg and kms_scan compiled first; short scan timers used.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module key_matrix_scan_encoder_tb_top;
  import kms_pkg::*;
  logic sys_clk, rstn, break_only, clk_en;
  logic [55:0] held;
  logic [7:0] row_drive;
  logic [6:0] col_sense;
  kms_tbl_wr_t tbl_wr;
  kms_key_t key_out;
  logic break_hit, case_inv;
  int bad_count, num_checks, cycles, hits;
  logic [7:0] codes[$];
  // ----------------------------------------------------------------
  // Design, matrix, clock and monitor
  // ----------------------------------------------------------------
  kms_scan #(.SCAN_CYC(200), .REPEAT_CYC(2000)) dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
    .row_drive(row_drive), .col_sense(col_sense),
    .break_only(break_only), .tbl_wr(tbl_wr), .key_out(key_out),
    .break_hit(break_hit), .case_inv(case_inv));
  kms_matrix_model mtx_u (
    .row_drive(row_drive), .held(held), .col_sense(col_sense));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Full scan is 376 cycles plus a 200 cycle gap, so 1300 spans two
  always @(posedge sys_clk) begin
    if (key_out.valid === 1'b1) codes.push_back(key_out.code);
    if (break_hit === 1'b1) hits++;
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      $display("wrong value at %0t: run too long", $time);
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic press(input logic [55:0] keys, input int n);
    codes.delete();
    hits = 0;
    held = held | keys;
    idle(n);
  endtask
  task automatic release_all(input string name);
    held = '0;
    idle(1300);
    $display("test %s done", name);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_order();
    press((56'h1 << 6'h00) | (56'h1 << 6'h11) | (56'h1 << 6'h2f), 1300);
    `CHK(codes.size(), 3)
    `CHK(codes[0], 8'h30)
    `CHK(codes[1], 8'h41)
    `CHK(codes[2], 8'h7f)
    release_all("order");
  endtask
  task automatic t_shift();
    press(56'h1 << SHIFT_IDX, 1300);
    `CHK(codes.size(), 0)
    press((56'h1 << 6'h01) | (56'h1 << 6'h11), 1300);
    `CHK(codes.size(), 2)
    `CHK(codes[0], 8'h21)
    `CHK(codes[1], 8'h61)
    release_all("shift");
  endtask
  task automatic t_ctrl();
    press(56'h1 << CTRL_IDX, 1300);
    `CHK(case_inv, 1'b1)
    `CHK(codes.size(), 0)
    held = '0;
    idle(1300);
    press(56'h1 << 6'h11, 1300);
    `CHK(codes[0], 8'h61)
    held = '0;
    idle(1300);
    press(56'h1 << CTRL_IDX, 1300);
    `CHK(case_inv, 1'b0)
    release_all("ctrl");
  endtask
  task automatic t_break();
    break_only = 1'b1;
    press((56'h1 << BRK_IDX) | (56'h1 << 6'h11), 1300);
    `CHK(hits, 1)
    `CHK(codes.size(), 0)
    break_only = 1'b0;
    held[BRK_IDX] = 1'b0;
    press('0, 1300);
    `CHK(codes.size(), 1)
    `CHK(codes[0], 8'h41)
    release_all("break");
  endtask
  task automatic t_repeat();
    press((56'h1 << REPT_IDX) | (56'h1 << 6'h12), 5000);
    `CHK(codes.size() >= 2, 1'b1)
    `CHK(codes[1], 8'h42)
    release_all("repeat");
  endtask
  task automatic t_table();
    tbl_wr = '{en: 1'b1, shifted: 1'b0, addr: 6'h11, data: 8'h99};
    idle(1);
    tbl_wr = '0;
    press(56'h1 << 6'h11, 1300);
    `CHK(codes.size(), 1)
    `CHK(codes[0], 8'h99)
    release_all("table");
  endtask
  // Clock enable low must freeze the scan: no code, rows held as they were
  task automatic t_freeze();
    logic [7:0] rd;
    rd = row_drive;
    clk_en = 1'b0;
    press(56'h1 << 6'h13, 1300);
    `CHK(codes.size(), 0)
    `CHK(row_drive, rd)
    clk_en = 1'b1;
    press('0, 1300);
    `CHK(codes.size(), 1)
    `CHK(codes[0], 8'h43)
    release_all("freeze");
  endtask
  initial begin
    rstn = 1'b0;
    break_only = 1'b0;
    clk_en = 1'b1;
    held = '0;
    tbl_wr = '0;
    idle(3);
    `CHK(row_drive, 8'h00)
    `CHK(case_inv, 1'b0)
    rstn = 1'b1;
    t_order();
    t_shift();
    t_ctrl();
    t_break();
    t_repeat();
    t_table();
    t_freeze();
    tally_and_finish();
  end
endmodule
`default_nettype wire
